/* hw/sfd_pkg.sv */
// Shared constants and types for the serial audio link coder and decoder
package sfd_pkg;

  // ----------------------------------------------------------------
  // Line timing
  // ----------------------------------------------------------------
  localparam int HALF_CELL_CYC = 8;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CELL_CYC - 1);
  localparam logic [9:0] NOM_TRIPLE_CYC = 10'(3 * HALF_CELL_CYC);
  localparam logic [9:0] WIDTH_MAX = 10'h3FF;

  // ----------------------------------------------------------------
  // Frame structure
  // ----------------------------------------------------------------
  localparam logic [7:0] LAST_FRAME = 8'hBF;
  localparam logic [7:0] PRE_BLOCK = 8'hE8;
  localparam logic [7:0] PRE_FIRST = 8'hE2;
  localparam logic [7:0] PRE_SECOND = 8'hE4;
  localparam logic [3:0] PRE_HALVES = 4'h8;
  localparam logic [3:0] PRE_SECOND_PULSE = 4'h3;
  localparam logic [5:0] FIRST_DATA_HALF = 6'h08;
  localparam logic [4:0] FIRST_DATA_SLOT = 5'h04;
  localparam logic [4:0] SLOT_BITS = 5'h1C;
  localparam int POS_WORD_LSB = 8;
  localparam int POS_VALID = 24;
  localparam int POS_USER = 25;
  localparam int POS_CSTAT = 26;
  localparam int POS_PARITY = 27;
  localparam logic [26:0] IDLE_WORD = 27'h1000000;

  // ----------------------------------------------------------------
  // Data bursts
  // ----------------------------------------------------------------
  localparam logic [15:0] SYNC_ONE = 16'hF872;
  localparam logic [15:0] SYNC_TWO = 16'h4E1F;
  localparam logic [15:0] WORD_BITS = 16'h0010;
  localparam logic [2:0] SYNC_ZERO_WORDS = 3'h4;
  localparam logic [13:0] BURST_MAX_WORDS = 14'h2000;
  localparam int INFO_ERR = 7;
  localparam int INFO_DEP_LSB = 8;
  localparam int INFO_STREAM_LSB = 13;
  localparam int INFO_RSV_LSB = 5;

  // ----------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------
  localparam int TX_WORD_W = 27;
  localparam int TX_FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PT_BLOCK = 2'h0,
    PT_FIRST = 2'h1,
    PT_SECOND = 2'h2
  } sfd_pre_t;

  typedef enum logic [2:0] {
    RX_HUNT = 3'h1,
    RX_PRE = 3'h2,
    RX_DATA = 3'h4
  } sfd_rx_state_t;

  typedef enum logic [4:0] {
    BU_SEARCH = 5'h01,
    BU_SYNC2 = 5'h02,
    BU_INFO = 5'h04,
    BU_LEN = 5'h08,
    BU_PAY = 5'h10
  } sfd_burst_state_t;

endpackage

/* hw/sfd_link_if.sv */
// Serial coded line between transmitter end and decoder end
`timescale 1ns/1ps
interface sfd_link_if;
  logic biphaseMarkLine;
  modport txEnd (output biphaseMarkLine);
  modport rxEnd (input biphaseMarkLine);
endinterface

/* hw/sfd_transmitter.sv */
// Sample FIFO and line coder for the transmitting end
`timescale 1ns/1ps
module sfd_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic inReady;
    logic outValid;
  } sfd_fifo_state_t;

  sfd_fifo_state_t s;
  sfd_fifo_state_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;

  always_comb begin
    next_s = s;
    push = inValid & s.inReady;
    if (push) begin
      next_s.wrPtr = s.wrPtr + 1'b1;
    end
    if (outReady & s.outValid) begin
      next_s.rdPtr = s.rdPtr + 1'b1;
    end
    next_s.outValid = next_s.wrPtr != next_s.rdPtr;
    next_s.inReady = !((next_s.wrPtr[AW] != next_s.rdPtr[AW]) &&
                       (next_s.wrPtr[AW-1:0] == next_s.rdPtr[AW-1:0]));
  end

  // Storage kept out of reset so it maps onto plain RAM
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[s.wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.inReady <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign inReady = s.inReady;
  assign outValid = s.outValid;
  assign outData = mem[s.rdPtr[AW-1:0]];
endmodule

module sfd_transmitter import sfd_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Sample input, first channel then second channel
  input wire logic inValid,
  output logic inReady,
  input wire logic [23:0] inSample,
  input wire logic inValidity,
  input wire logic inUser,
  input wire logic inChanStatus,
  // Mode and status
  input wire logic dataMode,
  output logic underrun,
  // Coded line
  sfd_link_if.txEnd link
);
  typedef struct packed {
    logic [3:0] div;
    logic [5:0] half;
    logic lvl;
    logic inv;
    logic chan;
    logic [7:0] frame;
    logic [7:0] pat;
    logic [27:0] word;
    logic underrun;
  } sfd_tx_state_t;

  sfd_tx_state_t s;
  sfd_tx_state_t next_s;
  logic fifoValid;
  logic pop;
  logic [TX_WORD_W-1:0] fifoData;
  logic [TX_WORD_W-1:0] fd;
  logic [27:0] w;
  logic [5:0] nh;
  logic [7:0] nframe;

  sfd_fifo #(
    .WIDTH(TX_WORD_W),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .inValid(inValid),
    .inReady(inReady),
    .inData({inChanStatus, inUser, inValidity, inSample}),
    .outValid(fifoValid),
    .outReady(pop),
    .outData(fifoData)
  );

  // ----------------------------------------------------------------
  // Half-cell sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.underrun = 1'b0;
    pop = 1'b0;
    nh = s.half + 6'h01;
    nframe = (s.frame == LAST_FRAME) ? 8'h00 : s.frame + 8'h01;
    fd = fifoValid ? fifoData : IDLE_WORD;
    w = {1'b0, fd};
    if (dataMode) begin
      w[7:0] = 8'h00;
      w[23:8] = fd[15:0];
    end
    w[POS_PARITY] = ^w[26:0];
    if (s.div == HALF_LAST) begin
      next_s.div = 4'h0;
      next_s.half = nh;
      if (nh == 6'h00) begin
        // New sub-frame: pick preamble, latch word, remember line level
        next_s.chan = ~s.chan;
        if (s.chan) begin
          next_s.frame = nframe;
          next_s.pat = (nframe == 8'h00) ? PRE_BLOCK : PRE_FIRST;
        end else begin
          next_s.pat = PRE_SECOND;
        end
        pop = fifoValid;
        next_s.underrun = ~fifoValid;
        next_s.word = w;
        next_s.inv = s.lvl;
        next_s.lvl = ~s.lvl;
      end else if (nh < FIRST_DATA_HALF) begin
        next_s.lvl = s.pat[3'h7 - nh[2:0]] ^ s.inv;
      end else if (!nh[0]) begin
        next_s.lvl = ~s.lvl;
      end else if (s.word[nh[5:1] - FIRST_DATA_SLOT]) begin
        next_s.lvl = ~s.lvl;
      end
    end else begin
      next_s.div = s.div + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.half <= 6'h3F;
      s.div <= HALF_LAST;
      s.chan <= 1'b1;
      s.frame <= LAST_FRAME;
    end else begin
      s <= next_s;
    end
  end

  assign link.biphaseMarkLine = s.lvl;
  assign underrun = s.underrun;
endmodule

/* hw/sfd_decoder.sv */
// Line decoder, frame tracker and data-burst finder for the receiving end
`timescale 1ns/1ps
module sfd_decoder import sfd_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Coded line
  sfd_link_if.rxEnd link,
  // Decoded sub-frame
  output logic sampleValid,
  output logic [23:0] sampleData,
  output logic sampleChannel,
  output logic validityBit,
  output logic user_bit_out,
  output logic chanStatusBit,
  output logic parityError,
  output logic blockStart,
  output logic [7:0] frameIndex,
  // Line status
  output logic locked,
  output logic codingError,
  // Serial user data
  output logic wordSelectOut,
  output logic userBitOut,
  // Data bursts
  output logic burstStart,
  output logic [15:0] burstLength,
  output logic [4:0] burstDataType,
  output logic burstPayloadError,
  output logic [4:0] burstTypeInfo,
  output logic [2:0] burstStreamNum,
  output logic burstInfoReserved,
  output logic burstAligned,
  output logic burstWordValid,
  output logic [15:0] burstWord
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [9:0] width;
    logic [9:0] triple;
    sfd_rx_state_t st;
    sfd_pre_t preType;
    logic [3:0] preHalf;
    logic mid;
    logic [4:0] bitCnt;
    logic [27:0] sh;
    sfd_burst_state_t bst;
    logic [2:0] zeroRun;
    logic [15:0] remain;
    logic [13:0] payCnt;
    logic sampleValid;
    logic [23:0] sampleData;
    logic sampleChannel;
    logic validityBit;
    logic user_bit_out;
    logic chanStatusBit;
    logic parityError;
    logic blockStart;
    logic [7:0] frameIndex;
    logic locked;
    logic codingError;
    logic wordSelectOut;
    logic userBitOut;
    logic burstStart;
    logic [15:0] burstLength;
    logic [4:0] burstDataType;
    logic burstPayloadError;
    logic [4:0] burstTypeInfo;
    logic [2:0] burstStreamNum;
    logic burstInfoReserved;
    logic burstAligned;
    logic burstWordValid;
    logic [15:0] burstWord;
  } sfd_rx_t;

  sfd_rx_t s;
  sfd_rx_t next_s;
  logic lineEdge;
  logic [12:0] wBig;
  logic [12:0] eBig;
  logic isShort;
  logic isLong;
  logic isTriple;
  logic [3:0] halves;
  logic [3:0] preSum;
  logic shift;
  logic bitVal;
  logic fail;
  logic emit;
  logic [27:0] shNew;
  logic [15:0] word;
  logic [4:0] dtype;

  always_comb begin
    next_s = s;
    next_s.s1 = link.biphaseMarkLine;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.sampleValid = 1'b0;
    next_s.blockStart = 1'b0;
    next_s.codingError = 1'b0;
    next_s.burstStart = 1'b0;
    next_s.burstWordValid = 1'b0;
    lineEdge = s.s2 ^ s.s3;

    // --------------------------------------------------------------
    // Pulse width classes against the last preamble's long pulse
    // --------------------------------------------------------------
    // Thresholds sit midway between 1, 2 and 3 half cells and at 4 half cells, and the
    // reference follows the sender, so slow drift is absorbed
    wBig = {3'h0, s.width};
    eBig = {3'h0, s.triple};
    isShort = (wBig * 13'h0002) < eBig;
    isLong = !isShort && ((wBig * 13'h0006) < (eBig * 13'h0005));
    isTriple = !isShort && !isLong &&
               ((wBig * 13'h0003) < (eBig * 13'h0004));
    halves = isShort ? 4'h1 : (isLong ? 4'h2 : 4'h3);
    preSum = s.preHalf + halves;
    shift = 1'b0;
    bitVal = 1'b0;
    fail = 1'b0;

    // --------------------------------------------------------------
    // Preamble and cell decoding
    // --------------------------------------------------------------
    if (lineEdge) begin
      next_s.width = 10'h001;
      if (!(isShort || isLong || isTriple)) begin
        fail = 1'b1;
      end else if (isTriple && s.st != RX_PRE) begin
        // Three half cells never appear inside coded data
        if (s.st == RX_DATA && s.bitCnt != SLOT_BITS) begin
          fail = 1'b1;
        end else begin
          next_s.st = RX_PRE;
          next_s.preHalf = PRE_SECOND_PULSE;
          next_s.triple = s.width;
        end
      end else begin
        case (s.st)
          RX_PRE: begin
            if (s.preHalf == PRE_SECOND_PULSE) begin
              // Second pulse width tells the three patterns apart
              next_s.preType = isTriple ? PT_FIRST :
                               (isLong ? PT_SECOND : PT_BLOCK);
            end
            if (preSum == PRE_HALVES) begin
              next_s.st = RX_DATA;
              next_s.bitCnt = 5'h00;
              next_s.mid = 1'b0;
            end else if (preSum > PRE_HALVES) begin
              fail = 1'b1;
            end else begin
              next_s.preHalf = preSum;
            end
          end
          RX_DATA: begin
            if (s.bitCnt == SLOT_BITS) begin
              fail = 1'b1;
            end else if (isShort) begin
              shift = s.mid;
              bitVal = 1'b1;
              next_s.mid = ~s.mid;
            end else if (isLong && !s.mid) begin
              shift = 1'b1;
            end else begin
              fail = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (s.width != WIDTH_MAX) begin
      next_s.width = s.width + 10'h001;
    end else if (s.st != RX_HUNT) begin
      fail = 1'b1;
    end

    if (fail) begin
      next_s.st = RX_HUNT;
      next_s.locked = 1'b0;
      next_s.bst = BU_SEARCH;
      next_s.codingError = 1'b1;
    end

    shNew = {bitVal, s.sh[27:1]};
    if (shift) begin
      next_s.sh = shNew;
      next_s.bitCnt = s.bitCnt + 5'h01;
    end
    emit = shift && (s.bitCnt == SLOT_BITS - 5'h01);
    word = shNew[POS_WORD_LSB +: 16];
    dtype = word[4:0];

    // --------------------------------------------------------------
    // Sub-frame results and frame position
    // --------------------------------------------------------------
    if (emit) begin
      next_s.locked = 1'b1;
      next_s.sampleValid = 1'b1;
      next_s.sampleData = shNew[23:0];
      next_s.validityBit = shNew[POS_VALID];
      next_s.user_bit_out = shNew[POS_USER];
      next_s.chanStatusBit = shNew[POS_CSTAT];
      next_s.parityError = ^shNew;
      next_s.sampleChannel = s.preType == PT_SECOND;
      next_s.wordSelectOut = s.preType == PT_SECOND;
      next_s.userBitOut = shNew[POS_USER];
      if (s.preType == PT_BLOCK) begin
        next_s.frameIndex = 8'h00;
        next_s.blockStart = 1'b1;
      end else if (s.preType == PT_FIRST) begin
        next_s.frameIndex = (s.frameIndex == LAST_FRAME) ?
                            8'h00 : s.frameIndex + 8'h01;
      end

      // ------------------------------------------------------------
      // Data-burst search
      // ------------------------------------------------------------
      if (word != 16'h0000) begin
        next_s.zeroRun = 3'h0;
      end else if (s.zeroRun != SYNC_ZERO_WORDS) begin
        next_s.zeroRun = s.zeroRun + 3'h1;
      end
      case (s.bst)
        BU_SEARCH: begin
          if (word == SYNC_ONE) begin
            next_s.bst = BU_SYNC2;
            next_s.burstAligned = s.zeroRun == SYNC_ZERO_WORDS;
          end
        end
        BU_SYNC2: begin
          if (word == SYNC_TWO) begin
            next_s.bst = BU_INFO;
          end else if (word != SYNC_ONE) begin
            next_s.bst = BU_SEARCH;
          end
        end
        BU_INFO: begin
          next_s.bst = BU_LEN;
          next_s.burstDataType = dtype;
          next_s.burstPayloadError = word[INFO_ERR];
          next_s.burstTypeInfo = word[INFO_DEP_LSB +: 5];
          next_s.burstStreamNum = word[INFO_STREAM_LSB +: 3];
          // Reserved type codes and non-zero reserved bits
          next_s.burstInfoReserved = (word[INFO_RSV_LSB +: 2] != 2'h0) ||
                                     (dtype == 5'h02) || (dtype == 5'h07) ||
                                     (dtype >= 5'h0A);
        end
        BU_LEN: begin
          next_s.burstLength = word;
          next_s.burstStart = 1'b1;
          next_s.remain = word;
          next_s.payCnt = 14'h0000;
          next_s.bst = (word == 16'h0000) ? BU_SEARCH : BU_PAY;
        end
        BU_PAY: begin
          next_s.burstWordValid = 1'b1;
          next_s.burstWord = word;
          next_s.payCnt = s.payCnt + 14'h0001;
          if (s.remain > WORD_BITS) begin
            next_s.remain = s.remain - WORD_BITS;
          end else begin
            next_s.remain = 16'h0000;
            next_s.bst = BU_SEARCH;
          end
          // A burst longer than allowed is cut off after its 8192nd word and search resumes
          if (s.payCnt == BURST_MAX_WORDS - 14'h0001) begin
            next_s.bst = BU_SEARCH;
          end
        end
        default: begin
          next_s.bst = BU_SEARCH;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.st <= RX_HUNT;
      s.bst <= BU_SEARCH;
      s.preType <= PT_BLOCK;
      s.triple <= NOM_TRIPLE_CYC;
    end else begin
      s <= next_s;
    end
  end

  assign sampleValid = s.sampleValid;
  assign sampleData = s.sampleData;
  assign sampleChannel = s.sampleChannel;
  assign validityBit = s.validityBit;
  assign user_bit_out = s.user_bit_out;
  assign chanStatusBit = s.chanStatusBit;
  assign parityError = s.parityError;
  assign blockStart = s.blockStart;
  assign frameIndex = s.frameIndex;
  assign locked = s.locked;
  assign codingError = s.codingError;
  assign wordSelectOut = s.wordSelectOut;
  assign userBitOut = s.userBitOut;
  assign burstStart = s.burstStart;
  assign burstLength = s.burstLength;
  assign burstDataType = s.burstDataType;
  assign burstPayloadError = s.burstPayloadError;
  assign burstTypeInfo = s.burstTypeInfo;
  assign burstStreamNum = s.burstStreamNum;
  assign burstInfoReserved = s.burstInfoReserved;
  assign burstAligned = s.burstAligned;
  assign burstWordValid = s.burstWordValid;
  assign burstWord = s.burstWord;
endmodule

/* tb/sfd_line_checker.sv */
// Checks on the coded line between the two ends
`timescale 1ns/1ps
module sfd_line_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Coded line
  input wire logic biphaseMarkLine
);
  // ---------------------------------------------------------------
  // Sub-frame position tracker
  // ---------------------------------------------------------------
  // Starts on the first line edge after reset, then free-runs
  logic prevLine;
  logic run;
  logic chg;
  logic [8:0] pos;
  logic [8:0] sf;
  assign chg = biphaseMarkLine != prevLine;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prevLine <= 1'b0;
      run <= 1'b0;
      pos <= 9'h000;
      sf <= 9'h000;
    end else begin
      prevLine <= biphaseMarkLine;
      if (run || chg) begin
        run <= 1'b1;
        pos <= pos + 9'h001;
      end
      if (run && pos == 9'h1FF) begin
        sf <= (sf == 9'h17F) ? 9'h000 : sf + 9'h001;
      end
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  cell_grid_a: assert property (
    run && pos[2:0] != 3'h0 |-> !chg) else $error("edge off the grid");
  cell_edge_a: assert property (
    run && pos >= 9'h040 && pos[3:0] == 4'h0 |-> chg)
    else $error("cell boundary without edge");
  frame_edge_a: assert property (
    run && pos == 9'h000 |-> chg) else $error("sub-frame without edge");
  pre_long_a: assert property (
    run && pos == 9'h008 |-> !chg ##8 !chg ##8 chg)
    else $error("no three-half pulse");
  parity_level_a: assert property (
    run && pos == 9'h1FF |-> !biphaseMarkLine ##1 biphaseMarkLine)
    else $error("odd ones in sub-frame");
  block_mark_a: assert property (
    run && pos == 9'h020 |-> chg == (sf == 9'h000))
    else $error("block preamble misplaced");
  chan_mark_a: assert property (
    run && pos == 9'h028 |-> chg == (sf[0] || sf == 9'h000))
    else $error("channel preamble wrong");
  pre_tail_a: assert property (
    run && pos == 9'h030 |-> (chg == (sf != 9'h000)) ##8
    (chg == (!sf[0] && sf != 9'h000)))
    else $error("preamble tail wrong");
endmodule

/* tb/sfd_decoder_tb.sv */
// Bench: transmitter end feeding decoder end over the coded line
`timescale 1ns/1ps
module sfd_decoder_tb import sfd_pkg::*; ;
  logic clk_sys, arst_n, inValid, inReady, inValidity, inUser;
  logic inChanStatus, dataMode, underrun, sampleValid, sampleChannel;
  logic validityBit, user_bit_out, chanStatusBit, parityError, blockStart;
  logic locked, codingError, wordSelectOut, userBitOut, burstStart;
  logic burstPayloadError, burstInfoReserved, burstAligned, burstWordValid;
  logic [23:0] inSample, sampleData;
  logic [7:0] frameIndex, lastFrame, nf;
  logic [15:0] burstLength, burstWord;
  logic [4:0] burstDataType, burstTypeInfo;
  logic [2:0] burstStreamNum;
  logic lastChan;
  int bad_count = 0, checks = 0, cycles = 0, nSeen = 0, nUnder = 0;
  logic [26:0] expQ[$];
  logic [15:0] wordQ[$];
  logic [31:0] burstQ[$];
  sfd_link_if link0 ();
  sfd_transmitter i_sfd_transmitter (.clk_sys(clk_sys), .arst_n(arst_n),
    .inValid(inValid), .inReady(inReady), .inSample(inSample),
    .inValidity(inValidity), .inUser(inUser), .inChanStatus(inChanStatus),
    .dataMode(dataMode), .underrun(underrun), .link(link0));
  sfd_decoder i_sfd_decoder (.clk_sys(clk_sys), .arst_n(arst_n),
    .link(link0), .sampleValid(sampleValid), .sampleData(sampleData),
    .sampleChannel(sampleChannel), .validityBit(validityBit),
    .user_bit_out(user_bit_out), .chanStatusBit(chanStatusBit),
    .parityError(parityError), .blockStart(blockStart),
    .frameIndex(frameIndex), .locked(locked), .codingError(codingError),
    .wordSelectOut(wordSelectOut), .userBitOut(userBitOut),
    .burstStart(burstStart), .burstLength(burstLength),
    .burstDataType(burstDataType), .burstPayloadError(burstPayloadError),
    .burstTypeInfo(burstTypeInfo), .burstStreamNum(burstStreamNum),
    .burstInfoReserved(burstInfoReserved), .burstAligned(burstAligned),
    .burstWordValid(burstWordValid), .burstWord(burstWord));
  sfd_line_checker i_sfd_line_checker (.clk_sys(clk_sys), .arst_n(arst_n),
    .biphaseMarkLine(link0.biphaseMarkLine));
  // ---------------------------------------------------------------
  // Clock, timeout and reporting
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input bit ok, input string what);
    checks++;
    if (!ok) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 70000) begin
      bad_count++;
      $display("[ERR] %0t run hung", $time);
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // Monitor of the decoder end
  // ---------------------------------------------------------------
  // Idle sub-frames (sample 0, validity 1) carry no pushed word
  task automatic collect();
    nf = (lastFrame == LAST_FRAME) ? 8'h00 : lastFrame + 8'h01;
    nf = lastChan ? nf : lastFrame;
    check(parityError === 1'b0, "parity flag");
    check(wordSelectOut === sampleChannel, "word select");
    check(userBitOut === user_bit_out, "user pin");
    if (nSeen == 0) begin
      check(blockStart === 1'b1 && frameIndex === 8'h00, "block");
    end else begin
      check(sampleChannel === ~lastChan && frameIndex === nf, "order");
    end
    if (!(sampleData === 24'h000000 && validityBit === 1'b1)) begin
      check(expQ.size() > 0 && {sampleData, validityBit, user_bit_out,
        chanStatusBit} === expQ.pop_front(), "fields");
    end
    nSeen++;
    lastFrame = frameIndex;
    lastChan = sampleChannel;
  endtask
  always @(negedge clk_sys) begin
    if (codingError === 1'b1) check(1'b0, "coding error");
    if (underrun === 1'b1) nUnder++;
    if (sampleValid === 1'b1) collect();
    if (burstWordValid === 1'b1) wordQ.push_back(burstWord);
    if (burstStart === 1'b1) burstQ.push_back({burstLength, burstDataType,
      burstPayloadError, burstTypeInfo, burstStreamNum, burstInfoReserved,
      burstAligned});
  end
  // ---------------------------------------------------------------
  // Drivers and scenarios
  // ---------------------------------------------------------------
  task automatic push(input logic [23:0] s, input logic [2:0] vuc);
    @(negedge clk_sys);
    inValid = 1'b1;
    inSample = s;
    {inValidity, inUser, inChanStatus} = vuc;
    @(posedge clk_sys);
    while (inReady !== 1'b1) @(posedge clk_sys);
    expQ.push_back(dataMode ? {s[15:0], 8'h00, vuc} : {s, vuc});
  endtask
  task automatic drain();
    @(negedge clk_sys);
    inValid = 1'b0;
    for (int i = 0; i < 30000 && expQ.size() > 0; i++) @(posedge clk_sys);
    repeat (1100) @(posedge clk_sys);
    check(expQ.size() == 0, "words lost");
  endtask
  // Overfills the buffer so inReady must drop before any pop
  task automatic pcm_fill();
    for (int k = 0; k < 40; k++) begin
      push(24'h13579B ^ (24'h0A0B0C * 24'(k)), 3'(k));
      if (k == 31) begin
        @(negedge clk_sys);
        check(inReady === 1'b0, "full buffer took word");
      end
    end
    drain();
  endtask
  // Aligned burst with error flag, then a bare burst of reserved type
  task automatic bursts();
    logic [15:0] w[16] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
      SYNC_ONE, SYNC_TWO, 16'h7385, 16'h0030, 16'h1234, 16'hABCD,
      16'h0F0F, SYNC_ONE, SYNC_TWO, 16'h0002, 16'h0010, 16'h8001};
    @(negedge clk_sys);
    dataMode = 1'b1;
    for (int k = 0; k < 16; k++) push({8'h5A, w[k]}, 3'h0);
    drain();
    check(burstQ.size() == 2, "burst count");
    check(burstQ[0] === 32'h00302E6D, "first burst");
    check(burstQ[1] === 32'h00101002, "second burst");
    check(wordQ.size() == 4 && wordQ[0] === 16'h1234 && wordQ[2] ===
      16'h0F0F && wordQ[3] === 16'h8001, "payload");
  endtask
  initial begin
    {arst_n, inValid, inValidity, inUser, inChanStatus, dataMode} = 6'h00;
    inSample = 24'h000000;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    pcm_fill();
    bursts();
    check(locked === 1'b1 && nUnder > 0, "lock or underrun");
    close_out();
  end
endmodule
